// ==== hw/dsz_pkg.sv ====
`default_nettype none
package dsz_pkg;

  // quarter-phase encoding of the instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_RESET = PH_Q1;

  // instruction word layout
  localparam logic [5:0] OPC_DECREMENT_SKIP_ZERO = 6'h0b;
  localparam int         OPC_MSB                 = 15;
  localparam int         OPC_LSB                 = 10;
  localparam int         DEST_BIT                = 9;
  localparam int         BANK_BIT                = 8;
  localparam int         FADDR_MSB               = 7;

  // addressing
  localparam logic [7:0] LITERAL_OFFSET_MAX = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK    = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK   = 4'hf;

  // skip lengths in instruction cycles
  localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
  localparam logic [1:0] SKIP_TWO_WORD = 2'h2;

  // reset values
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [1:0]  SKIP_RESET = 2'h0;

  typedef enum logic [0:0] {ST_RUN, ST_SKIP} exec_state_e;

endpackage
`default_nettype wire

// ==== hw/quarter_phase_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module quarter_phase_gen
  import dsz_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // current quarter of the instruction cycle
  output logic      [1:0] phase_q
);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase_q <= PH_RESET;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

endmodule
`default_nettype wire

// ==== hw/decrement_skip_when_zero.sv ====
// Summary of operation
// - the instruction is recognised by opcode bits 0010 11, then d, a and an 8-bit address.
// - the addressed byte is decremented by one with 8-bit wraparound.
// - with d at 0 the result goes to the working register and memory is untouched.
// - with d at 1 the result is written back to the addressed byte.
// - a zero result discards the already fetched next instruction and runs a no-op instead.
// - one cycle without skip, two cycles when a one-word instruction is skipped.
// - with a at 0, except for indexed literal offsets, the address lies in the fixed access bank, ignoring the bank select register.
// - with a at 1 the bank select register supplies the upper address bits.
// - with a at 0 and the extended set on, addresses up to 95 are indexed literal offsets.
// - skipping a two-word instruction inserts two no-op cycles, three cycles in total.
`timescale 1ns/1ps
`default_nettype none
module decrement_skip_when_zero
  import dsz_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // fetched instruction
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        next_is_two_word,
  // addressing context
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  // data memory
  input  wire logic [7:0]  rd_data,
  output logic             mem_rd_q,
  output logic      [11:0] mem_addr_q,
  output logic             mem_we_q,
  output logic      [7:0]  mem_wdata_q,
  // working register
  output logic             w_we_q,
  output logic      [7:0]  w_data_q,
  // fetch control
  output logic             skip_active_q,
  output logic      [1:0]  phase_q
);

  function automatic logic is_ours(input logic [15:0] w);
    return w[OPC_MSB:OPC_LSB] == OPC_DECREMENT_SKIP_ZERO;
  endfunction

  function automatic logic [11:0] resolve_addr(input logic       a,
                                               input logic       ext,
                                               input logic [7:0] f,
                                               input logic [3:0] bank,
                                               input logic [11:0] base);
    logic [11:0] r;
    r = {bank, f};
    if (!a) begin
      if (ext && f <= LITERAL_OFFSET_MAX) begin
        r = base + {4'h0, f};
      end else if (f <= LITERAL_OFFSET_MAX) begin
        r = {ACCESS_LOW_BANK, f};
      end else begin
        r = {ACCESS_HIGH_BANK, f};
      end
    end
    return r;
  endfunction

  logic        act_q;
  logic        d_q;
  logic        a_q;
  logic        ext_q;
  logic [7:0]  f_q;
  logic [7:0]  result_q;
  logic [1:0]  skip_left_q;
  exec_state_e state_q;

  quarter_phase_gen u_phase (
    .core_clk (core_clk),
    .rstn     (rstn),
    .phase_q  (phase_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode in Q1; a word fetched while skipping is never decoded
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      act_q      <= 1'b0;
      d_q        <= 1'b0;
      a_q        <= 1'b0;
      ext_q      <= 1'b0;
      f_q        <= BYTE_RESET;
      mem_addr_q <= ADDR_RESET;
      mem_rd_q   <= 1'b0;
    end else if (phase_q == PH_Q1) begin
      act_q    <= instr_valid && is_ours(instr_word) && state_q == ST_RUN;
      mem_rd_q <= instr_valid && is_ours(instr_word) && state_q == ST_RUN;
      d_q      <= instr_word[DEST_BIT];
      a_q      <= instr_word[BANK_BIT];
      ext_q    <= ext_set_en;
      f_q      <= instr_word[FADDR_MSB:0];
      mem_addr_q <= resolve_addr(instr_word[BANK_BIT], ext_set_en,
                                 instr_word[FADDR_MSB:0], bank_select_register,
                                 index_base);
    end else begin
      mem_rd_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compute in Q3: memory answers one edge after the Q2 read strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      result_q <= BYTE_RESET;
    end else if (phase_q == PH_Q3) begin
      result_q <= rd_data - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write destination in Q4; status flags have no write path from here at all
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mem_we_q    <= 1'b0;
      mem_wdata_q <= BYTE_RESET;
      w_we_q      <= 1'b0;
      w_data_q    <= BYTE_RESET;
    end else if (phase_q == PH_Q4 && act_q) begin
      mem_we_q    <= d_q;
      mem_wdata_q <= result_q;
      w_we_q      <= !d_q;
      w_data_q    <= result_q;
    end else begin
      mem_we_q <= 1'b0;
      w_we_q   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip: the squashed word still costs whole instruction cycles of no-op
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q       <= ST_RUN;
      skip_left_q   <= SKIP_RESET;
      skip_active_q <= 1'b0;
    end else if (phase_q == PH_Q4) begin
      case (state_q)
        ST_RUN: begin
          if (act_q && result_q == 8'h00) begin
            state_q       <= ST_SKIP;
            skip_active_q <= 1'b1;
            skip_left_q   <= next_is_two_word ? SKIP_TWO_WORD : SKIP_ONE_WORD;
          end
        end
        ST_SKIP: begin
          skip_left_q <= skip_left_q - 2'h1;
          if (skip_left_q == SKIP_ONE_WORD) begin
            state_q       <= ST_RUN;
            skip_active_q <= 1'b0;
          end
        end
        default: begin
          state_q       <= ST_RUN;
          skip_active_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_decode;
    phase_q == PH_Q1 && instr_valid && is_ours(instr_word) && state_q == ST_RUN
      |=> act_q && mem_rd_q;
  endproperty
  a_decode: assert property (p_decode) else $error("opcode not taken");

  property p_decrement;
    mem_we_q || w_we_q |-> (mem_we_q ? mem_wdata_q : w_data_q) == $past(rd_data, 2) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) else $error("bad decrement");

  property p_dest_w;
    w_we_q |-> !mem_we_q && !d_q;
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("w write wrong");

  property p_dest_f;
    phase_q == PH_Q4 && act_q && d_q |=> mem_we_q && !w_we_q;
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("memory write missing");

  property p_skip_start;
    phase_q == PH_Q4 && act_q && result_q == 8'h00 |=> skip_active_q;
  endproperty
  a_skip_start: assert property (p_skip_start) else $error("skip not raised");

  property p_skip_one;
    $rose(skip_active_q) && skip_left_q == SKIP_ONE_WORD |-> skip_active_q[*4] ##1 !skip_active_q;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("one-word skip length");

  property p_skip_two;
    $rose(skip_active_q) && skip_left_q == SKIP_TWO_WORD |-> skip_active_q[*8] ##1 !skip_active_q;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip length");

  property p_access_bank;
    mem_rd_q && !a_q && !(ext_q && f_q <= LITERAL_OFFSET_MAX)
      |-> mem_addr_q == {(f_q <= LITERAL_OFFSET_MAX) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f_q};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address");

  property p_banked;
    mem_rd_q && a_q |-> mem_addr_q == {$past(bank_select_register), f_q};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address");

  property p_indexed;
    mem_rd_q && !a_q && ext_q && f_q <= LITERAL_OFFSET_MAX
      |-> mem_addr_q == $past(index_base) + {4'h0, f_q};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address");

  property p_quarters;
    (mem_rd_q |-> phase_q == PH_Q2) and (mem_we_q || w_we_q |-> phase_q == PH_Q1);
  endproperty
  a_quarters: assert property (p_quarters) else $error("wrong quarter");

  c_write_w:   cover property (w_we_q);
  c_write_f:   cover property (mem_we_q);
  c_skip_one:  cover property ($rose(skip_active_q) && skip_left_q == SKIP_ONE_WORD);
  c_skip_two:  cover property ($rose(skip_active_q) && skip_left_q == SKIP_TWO_WORD);

endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import dsz_pkg::*;
;
  logic        core_clk, rstn, instr_valid, next_is_two_word, ext_set_en;
  logic [15:0] instr_word;
  logic [3:0]  bank_select_register;
  logic [11:0] index_base, mem_addr_q;
  logic [7:0]  rd_data, mem_wdata_q, w_data_q;
  logic        mem_rd_q, mem_we_q, w_we_q, skip_active_q;
  logic [1:0]  phase_q;
  int          fails, checks;

  decrement_skip_when_zero uut (
    .core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .next_is_two_word(next_is_two_word),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
    .index_base(index_base), .rd_data(rd_data), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q),
    .w_we_q(w_we_q), .w_data_q(w_data_q), .skip_active_q(skip_active_q),
    .phase_q(phase_q));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [15:0] mk(input logic d, input logic a, input logic [7:0] f);
    return {OPC_DECREMENT_SKIP_ZERO, d, a, f};
  endfunction

  // waits for a q1 slot, so back-to-back issue is exercised when none is lost
  task automatic op(input logic [15:0] w, input logic [3:0] bank, input logic ext,
                    input logic [11:0] base, input logic [7:0] rd, input logic two,
                    input logic [11:0] ea, input logic dm, input logic [7:0] ev,
                    input int sk);
    int n;
    n = 0;
    while (phase_q !== PH_Q1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    {instr_valid, instr_word, bank_select_register, ext_set_en} = {1'b1, w, bank, ext};
    {index_base, rd_data, next_is_two_word} = {base, rd, two};
    @(negedge core_clk);
    chk("rd strobe", 16'(mem_rd_q), 16'(1'b1));
    chk("rd phase", 16'(phase_q), 16'(PH_Q2));
    chk("address", 16'(mem_addr_q), 16'(ea));
    repeat (3) @(negedge core_clk);
    chk("wr phase", 16'(phase_q), 16'(PH_Q1));
    chk("mem we", 16'(mem_we_q), 16'(dm));
    chk("w we", 16'(w_we_q), 16'(!dm));
    chk("result", 16'(dm ? mem_wdata_q : w_data_q), 16'(ev));
    // the decrement stays offered through the skip, so a lost squash re-executes it;
    // the caller replaces or drops it before the next q1 edge
    n = 0;
    while (skip_active_q === 1'b1 && n < 20) begin
      chk("squash", 16'(mem_rd_q), 16'h0000);
      @(negedge core_clk);
      n++;
    end
    chk("skip length", 16'(n), 16'(sk));
  endtask

  task automatic other_opcode();
    instr_valid = 1'b0;
    @(negedge core_clk);
    while (phase_q !== PH_Q1) @(negedge core_clk);
    instr_word = 16'h2840;
    instr_valid = 1'b1;
    repeat (5) begin
      @(negedge core_clk);
      chk("foreign rd", 16'({mem_rd_q, mem_we_q, w_we_q}), 16'h0000);
    end
    instr_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    results();
  end

  initial begin
    fails = 0;
    checks = 0;
    {rstn, instr_valid, next_is_two_word, ext_set_en} = 4'h0;
    {instr_word, bank_select_register, index_base, rd_data} = '0;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    op(mk(1'b1, 1'b1, 8'h40), 4'h3, 1'b0, 12'h000, 8'h05, 1'b0, 12'h340, 1'b1, 8'h04, 0);
    op(mk(1'b0, 1'b0, 8'h10), 4'h7, 1'b0, 12'h200, 8'h00, 1'b0, 12'h010, 1'b0, 8'hff, 0);
    op(mk(1'b0, 1'b0, 8'h60), 4'h7, 1'b1, 12'h200, 8'h01, 1'b0, 12'hf60, 1'b0, 8'h00, 4);
    op(mk(1'b1, 1'b0, 8'h5f), 4'h7, 1'b1, 12'h200, 8'h01, 1'b1, 12'h25f, 1'b1, 8'h00, 8);
    op(mk(1'b1, 1'b1, 8'h5f), 4'h4, 1'b1, 12'h200, 8'h80, 1'b1, 12'h45f, 1'b1, 8'h7f, 0);
    other_opcode();
    results();
  end
endmodule
`default_nettype wire
